/* File: inc/lmc_pkg.sv */
// package with frame layout constants and command codes for the decoder
// ***********************************************************************
// ***********************************************************************
package lmc_pkg;
  // ***********************************************************************
  // frame constants
  // ***********************************************************************
  localparam logic [5:0] LMC_ID_APP      = 6'h3c;
  localparam logic [7:0] LMC_APP_OPCODE  = 8'h80;
  localparam logic [6:0] LMC_OP_TWO_SPD  = 7'h08;
  localparam logic [6:0] LMC_OP_MOTOR    = 7'h09;
  localparam logic [6:0] LMC_OP_FUSE     = 7'h10;
  localparam logic [6:0] LMC_OP_STALL    = 7'h16;
  localparam logic [6:0] LMC_OP_ZERO     = 7'h06;
  localparam logic [6:0] LMC_OP_ABS      = 7'h0b;
  localparam logic [7:0] LMC_FILL        = 8'hff;
  localparam logic [3:0] LMC_FUSE_HI     = 4'hf;
  localparam int         LMC_NBYTES      = 8;
  localparam logic [3:0] LMC_LEN_SHORT   = 4'h2;
  localparam logic [3:0] LMC_LEN_FULL    = 4'h8;
  localparam logic [15:0] LMC_POS_RST    = 16'h0000;
  localparam logic [6:0] LMC_NODE_RST    = 7'h00;
endpackage : lmc_pkg

/* File: inc/lmc_if.sv */
// interface joining the frame sender and the frame decoder
`timescale 1ns/1ps
interface lmc_if;
  logic [5:0]  frame_id;     // frame identifier
  logic [63:0] frame_data;   // data byte one in bits 63:56
  logic [3:0]  frame_len;    // number of data bytes
  logic        frame_valid;  // one-cycle strobe, frame complete
  modport sender  (output frame_id, frame_data, frame_len, frame_valid);
  modport decoder (input  frame_id, frame_data, frame_len, frame_valid);
endinterface : lmc_if

/* File: hw/lmc_sender.sv */
// master end: apb registers that build and send one frame
`timescale 1ns/1ps
module lmc_sender
  import lmc_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  lmc_if.sender            link
);
  // ***********************************************************************
  // register map
  // ***********************************************************************
  localparam logic [11:0] ADDR_HI   = 12'h000;
  localparam logic [11:0] ADDR_LO   = 12'h004;
  localparam logic [11:0] ADDR_CTRL = 12'h008;
  localparam logic [11:0] ADDR_STAT = 12'h00c;

  logic [31:0] data_hi;
  logic [31:0] data_lo;
  logic [5:0]  id_reg;
  logic [3:0]  len_reg;
  logic [15:0] sent_cnt;
  logic        send_q;

  wire wr_en  = psel & penable & pwrite;
  wire hit_hi = paddr == ADDR_HI;
  wire hit_lo = paddr == ADDR_LO;
  wire hit_ct = paddr == ADDR_CTRL;
  wire hit_st = paddr == ADDR_STAT;
  wire mapped = hit_hi | hit_lo | hit_ct | hit_st;
  // ctrl write with bit 31 launches the frame
  wire launch = wr_en & hit_ct & pwdata[31];

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = hit_hi ? data_hi :
                   hit_lo ? data_lo :
                   hit_ct ? {22'h000000, len_reg, id_reg} :
                   hit_st ? {16'h0000, sent_cnt} : 32'h00000000;

  // register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_hi <= 32'h00000000;
      data_lo <= 32'h00000000;
      id_reg  <= 6'h00;
      len_reg <= 4'h0;
    end else if (wr_en) begin
      if (hit_hi) data_hi <= pwdata;
      if (hit_lo) data_lo <= pwdata;
      if (hit_ct) begin
        id_reg  <= pwdata[5:0];
        len_reg <= pwdata[9:6];
      end
    end
  end

  // frame strobe one cycle after the launching write; the frame layout
  // is software's duty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      send_q   <= 1'b0;
      sent_cnt <= 16'h0000;
    end else begin
      send_q <= launch;
      if (launch) sent_cnt <= sent_cnt + 16'h0001;
    end
  end

  assign link.frame_id    = id_reg;
  assign link.frame_data  = {data_hi, data_lo};
  assign link.frame_len   = len_reg;
  assign link.frame_valid = send_q;
endmodule : lmc_sender

/* File: hw/lmc_decoder.sv */
// device end: decodes write frames into motion and parameter updates
`timescale 1ns/1ps
module lmc_decoder
  import lmc_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // link
  lmc_if.decoder           link,
  // node identity and motion state
  input  wire logic [6:0]  node_addr,
  input  wire logic        move_done,
  // position outputs
  output logic      [15:0] actual_position,
  output logic      [15:0] target_position,
  output logic      [3:0]  speed_max,
  output logic      [3:0]  speed_min,
  output logic             move_start,
  output logic             two_speed_busy,
  output logic             reference_done,
  // configuration outputs
  output logic      [3:0]  run_current,
  output logic      [3:0]  hold_current,
  output logic      [2:0]  sample_floor,
  output logic             direction_sel,
  output logic      [3:0]  ramp_rate,
  output logic      [3:0]  absolute_threshold,
  output logic      [2:0]  undervolt_threshold,
  output logic      [2:0]  fullstep_stall_en,
  output logic             ramp_profile_sel,
  output logic      [1:0]  microstep_sel,
  output logic             full_duty_stall_en,
  output logic             chop_jitter_en,
  output logic      [10:0] safe_position,
  output logic      [1:0]  settle_time,
  output logic             chop_rate_sel,
  output logic             boost_disable,
  // fuse programming
  output logic             fuse_write,
  output logic      [3:0]  fuse_byte_addr,
  output logic      [7:0]  fuse_data
);
  typedef enum logic [1:0] {IDLE, FIRST, SECOND} lmc_seq_e;
  lmc_seq_e state;

  // byte n of the frame, n from 1
  function automatic logic [7:0] lmc_byte(input logic [63:0] d,
                                         input int n);
    lmc_byte = d[(LMC_NBYTES-n)*8 +: 8];
  endfunction : lmc_byte

  // ***********************************************************************
  // frame decode
  // ***********************************************************************
  wire [63:0] d   = link.frame_data;
  wire [7:0]  b1  = lmc_byte(d, 1);
  wire [7:0]  b2  = lmc_byte(d, 2);
  wire [7:0]  b3  = lmc_byte(d, 3);
  wire [7:0]  b4  = lmc_byte(d, 4);
  wire [7:0]  b5  = lmc_byte(d, 5);
  wire [7:0]  b6  = lmc_byte(d, 6);
  wire [7:0]  b7  = lmc_byte(d, 7);
  wire [7:0]  b8  = lmc_byte(d, 8);
  wire app_frame  = link.frame_valid & (link.frame_id == LMC_ID_APP) &
                    (link.frame_len == LMC_LEN_FULL) &
                    (b1 == LMC_APP_OPCODE) & b2[7];
  wire app_me     = ~b3[7] | (b3[6:0] == node_addr);
  wire app_go     = app_frame & app_me;
  wire op_two     = app_go & (b2[6:0] == LMC_OP_TWO_SPD);
  wire op_stall   = app_go & (b2[6:0] == LMC_OP_STALL);
  wire op_motor   = app_go & (b2[6:0] == LMC_OP_MOTOR);
  wire op_fuse    = app_go & (b2[6:0] == LMC_OP_FUSE) &
                    (b4[7:4] == LMC_FUSE_HI) & (b6 == LMC_FILL) &
                    (b7 == LMC_FILL) & (b8 == LMC_FILL);
  // short command frame: opcode, broadcast and node byte
  wire gp_frame   = link.frame_valid & (link.frame_len >= LMC_LEN_SHORT) &
                    b1[7] & (~b2[7] | (b2[6:0] == node_addr));
  wire op_zero    = gp_frame & (b1[6:0] == LMC_OP_ZERO);
  wire op_abs     = gp_frame & (b1[6:0] == LMC_OP_ABS);
  wire busy       = state != IDLE;
  wire take_two   = op_two & ~busy;
  wire take_abs   = op_abs & ~busy;
  wire take_zero  = op_zero & ~busy;

  // ***********************************************************************
  // two-speed sequence and positions
  // ***********************************************************************
  logic [15:0] offset_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state           <= IDLE;
      offset_q        <= LMC_POS_RST;
      actual_position <= LMC_POS_RST;
      target_position <= LMC_POS_RST;
      move_start      <= 1'b0;
      reference_done  <= 1'b0;
    end else begin
      move_start <= 1'b0;
      case (state)
        IDLE: begin
          if (take_two) begin
            target_position <= {b5, b6};
            offset_q        <= {b7, b8};
            move_start      <= 1'b1;
            state           <= FIRST;
          end else if (take_zero) begin
            actual_position <= LMC_POS_RST;
            target_position <= LMC_POS_RST;
            reference_done  <= 1'b1;
          end else if (take_abs) begin
            target_position <= {b3, b4};
            move_start      <= 1'b1;
          end else if (move_done) begin
            actual_position <= target_position;
          end
        end
        FIRST: begin
          if (move_done) begin
            actual_position <= target_position;
            target_position <= target_position + offset_q;
            move_start      <= 1'b1;
            state           <= SECOND;
          end
        end
        SECOND: begin
          if (move_done) begin
            actual_position <= target_position;
            reference_done  <= 1'b1;
            state           <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end
  assign two_speed_busy = busy;

  // ***********************************************************************
  // speeds: second motion runs at speed_min only
  // ***********************************************************************
  logic [3:0] cfg_max;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_max   <= 4'h0;
      speed_min <= 4'h0;
    end else if (take_two) begin
      cfg_max   <= b4[7:4];
      speed_min <= b4[3:0];
    end else if (op_stall | op_motor) begin
      cfg_max   <= b5[7:4];
      speed_min <= b5[3:0];
    end
  end
  assign speed_max = (state == SECOND) ? speed_min : cfg_max;

  // ***********************************************************************
  // parameter ram
  // ***********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_current         <= 4'h0;
      hold_current        <= 4'h0;
      direction_sel       <= 1'b0;
      ramp_rate           <= 4'h0;
      ramp_profile_sel    <= 1'b0;
      microstep_sel       <= 2'h0;
      chop_jitter_en      <= 1'b0;
      sample_floor        <= 3'h0;
      absolute_threshold  <= 4'h0;
      undervolt_threshold <= 3'h0;
      fullstep_stall_en   <= 3'h0;
      full_duty_stall_en  <= 1'b0;
      safe_position       <= 11'h000;
      settle_time         <= 2'h0;
      chop_rate_sel       <= 1'b0;
      boost_disable       <= 1'b0;
    end else if (op_stall | op_motor) begin
      // applied at once, even while a motion runs
      run_current      <= b4[7:4];
      hold_current     <= b4[3:0];
      direction_sel    <= b6[4];
      ramp_rate        <= b6[3:0];
      ramp_profile_sel <= b8[4];
      microstep_sel    <= b8[3:2];
      chop_jitter_en   <= b8[0];
      if (op_stall) begin
        sample_floor        <= b6[7:5];
        absolute_threshold  <= b7[7:4];
        undervolt_threshold <= b7[2:0];
        fullstep_stall_en   <= b8[7:5];
        full_duty_stall_en  <= b8[1];
      end else begin
        safe_position <= {b6[7:5], b7};
        settle_time   <= {b8[7], b8[5]};
        chop_rate_sel <= b8[6];
        boost_disable <= b8[1];
      end
    end
  end

  // ***********************************************************************
  // fuse programming strobe
  // ***********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_write     <= 1'b0;
      fuse_byte_addr <= 4'h0;
      fuse_data      <= 8'h00;
    end else begin
      fuse_write <= op_fuse;
      if (op_fuse) begin
        fuse_byte_addr <= {~b4[3], b4[2:0]};
        fuse_data      <= b5;
      end
    end
  end
endmodule : lmc_decoder

/* File: dv/lmc_link_assertions.sv */
// concurrent checks on the frame link
`timescale 1ns/1ps
module lmc_link_assertions
  import lmc_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // link
  input wire logic [5:0]  frame_id,
  input wire logic [63:0] frame_data,
  input wire logic [3:0]  frame_len,
  input wire logic        frame_valid
);
  // ****************************************
  // app frame shapes
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence app_hdr(logic [6:0] op);
    frame_valid && frame_data[63:55] == {LMC_APP_OPCODE, 1'h1}
      && frame_data[54:48] == op;
  endsequence
  sequence full_frame;
    frame_id == LMC_ID_APP && frame_len == LMC_LEN_FULL;
  endsequence
  property app_frame(logic [6:0] op);
    app_hdr(op) |-> full_frame;
  endproperty
  two_speed_a: assert property (app_frame(LMC_OP_TWO_SPD))
    else $error("two-speed frame malformed");
  stall_frame_a: assert property (app_frame(LMC_OP_STALL))
    else $error("stall frame malformed");
  motor_frame_a: assert property (app_frame(LMC_OP_MOTOR))
    else $error("motor frame malformed");
  fuse_frame_a: assert property (app_frame(LMC_OP_FUSE))
    else $error("fuse frame malformed");
  fuse_fill_a: assert property (app_hdr(LMC_OP_FUSE) |->
    frame_data[39:36] == LMC_FUSE_HI && frame_data[23:0] == 24'hffffff)
    else $error("fuse frame fill wrong");
  // strobe is one cycle and the payload is settled before it
  valid_pulse_a: assert property (frame_valid |=> !frame_valid)
    else $error("frame strobe longer than one cycle");
  data_hold_a: assert property (frame_valid |-> $stable(frame_data))
    else $error("payload moved under strobe");
endmodule : lmc_link_assertions

/* File: dv/tb.sv */
// testbench: apb-driven sender feeding the decoder
`timescale 1ns/1ps
module tb;
  import lmc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  node_addr;
  logic        move_done, move_start, two_speed_busy, reference_done;
  logic [15:0] actual_position, target_position;
  logic [3:0]  speed_max, speed_min, run_current, hold_current, ramp_rate;
  logic [3:0]  absolute_threshold, fuse_byte_addr;
  logic [2:0]  sample_floor, undervolt_threshold, fullstep_stall_en;
  logic [1:0]  microstep_sel, settle_time;
  logic [10:0] safe_position;
  logic [7:0]  fuse_data;
  logic        direction_sel, ramp_profile_sel, full_duty_stall_en;
  logic        chop_jitter_en, chop_rate_sel, boost_disable, fuse_write;
  int          n_mismatch, n_checks;
  lmc_if link();
  lmc_sender lmc_sender_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .link(link));
  lmc_decoder lmc_decoder_inst (.pclk, .presetn, .link(link), .node_addr,
    .move_done, .actual_position, .target_position, .speed_max, .speed_min,
    .move_start, .two_speed_busy, .reference_done, .run_current,
    .hold_current, .sample_floor, .direction_sel, .ramp_rate,
    .absolute_threshold, .undervolt_threshold, .fullstep_stall_en,
    .ramp_profile_sel, .microstep_sel, .full_duty_stall_en, .chop_jitter_en,
    .safe_position, .settle_time, .chop_rate_sel, .boost_disable,
    .fuse_write, .fuse_byte_addr, .fuse_data);
  lmc_link_assertions u_chk (.pclk, .presetn, .frame_id(link.frame_id),
    .frame_data(link.frame_data), .frame_len(link.frame_len),
    .frame_valid(link.frame_valid));
  // 250 mhz clock
  always #2 pclk = ~pclk;
  // ****************************************
  // tasks
  // ****************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (k == 20) begin
      n_mismatch++;
      finish_test();
    end
    rd = prdata;
    chk("pslverr", {31'h0, a > 12'h00c}, {31'h0, pslverr});
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // load payload, trigger, wait until the decoder has taken the frame
  task automatic send(input logic [5:0] id, input logic [3:0] ln,
                      input logic [31:0] hi, input logic [31:0] lo);
    int k;
    apb(1'h1, 12'h000, hi);
    apb(1'h1, 12'h004, lo);
    apb(1'h1, 12'h008, {1'h1, 21'h0, ln, id});
    // the strobe stands for one cycle right after the launching write
    for (k = 0; k < 20; k++) begin
      #1;
      if (link.frame_valid === 1'h1) break;
      @(posedge pclk);
    end
    if (k == 20) begin
      n_mismatch++;
      finish_test();
    end
    @(posedge pclk);
    #1;
  endtask : send
  task automatic done_pulse();
    @(posedge pclk);
    move_done <= 1'h1;
    @(posedge pclk);
    move_done <= 1'h0;
    #1;
  endtask : done_pulse
  task automatic fuse(input logic [7:0] b3, input logic [7:0] b4,
                      input logic [3:0] ea);
    send(LMC_ID_APP, 4'h8, {16'h8090, b3, b4}, 32'h3cffffff);
    chk("fuse", {19'h0, 1'h1, ea, 8'h3c},
        {19'h0, fuse_write, fuse_byte_addr, fuse_data});
  endtask : fuse
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {pclk, presetn, psel, penable, pwrite, move_done} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    node_addr = 7'h12;
    n_mismatch = 0;
    n_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 12'h010, 32'h0);
    chk("unmapped", 32'h0, rd);
    send(LMC_ID_APP, 4'h8, 32'h809692a5, 32'h3c7b955e);
    chk("stall a", {4'ha, 4'h5, 3'h3, 1'h1, 4'hb, 4'h9, 3'h5, 4'h3, 4'hc},
        {run_current, hold_current, sample_floor, direction_sel, ramp_rate,
         absolute_threshold, undervolt_threshold, speed_max,
         speed_min});
    chk("stall b", {3'h2, 1'h1, 2'h3, 1'h1, 1'h0}, {fullstep_stall_en,
        ramp_profile_sel, microstep_sel, full_duty_stall_en,
        chop_jitter_en});
    apb(1'h0, 12'h000, 32'h0);
    chk("data hi read", 32'h809692a5, rd);
    send(LMC_ID_APP, 4'h8, 32'h8089056d, 32'h47d321a2);
    chk("motor", {11'h621, 2'h3, 1'h0, 1'h1, 4'h6, 4'hd, 1'h1, 4'h3},
        {safe_position, settle_time, chop_rate_sel, boost_disable,
         run_current, hold_current, direction_sel, ramp_rate});
    send(LMC_ID_APP, 4'h8, 32'h808985ff, 32'hffffffff);
    chk("other node", {11'h621, 4'h6}, {safe_position, run_current});
    fuse(8'h92, 8'hf5, 4'hd);
    fuse(8'h05, 8'hfd, 4'h5);
    send(6'h00, 4'h4, 32'h8b920040, 32'h0);
    chk("abs", {16'h0040, 1'h1}, {target_position, move_start});
    done_pulse();
    chk("abs done", 32'h40, {16'h0, actual_position});
    send(6'h00, 4'h2, 32'h86000000, 32'h0);
    chk("zero", {16'h0, 16'h0}, {actual_position, target_position});
    chk("zero ref", 32'h1, {31'h0, reference_done});
    apb(1'h0, 12'h00c, 32'h0);
    chk("sent count", 32'h7, {16'h0, rd[15:0]});
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    chk("reset ref", 32'h0, {31'h0, reference_done});
    presetn <= 1'h1;
    send(LMC_ID_APP, 4'h8, 32'h80881273, 32'h01000020);
    chk("two a", {16'h0100, 1'h1, 1'h1}, {target_position, move_start,
        two_speed_busy});
    chk("two a spd", {4'h7, 4'h3}, {speed_max, speed_min});
    // speeds only, other fields as they stand after reset
    send(LMC_ID_APP, 4'h8, 32'h80891200, 32'h59000000);
    chk("speed in motion", {4'h5, 4'h9, 4'h0, 1'h1, 16'h0100},
        {speed_max, speed_min, run_current, two_speed_busy,
         target_position});
    send(6'h00, 4'h4, 32'h8b120300, 32'h0);
    chk("no abort", 32'h0100, {16'h0, target_position});
    done_pulse();
    chk("two b", {16'h0100, 16'h0120}, {actual_position,
        target_position});
    chk("two spd", {4'h9, 4'h9, 1'h1}, {speed_max, speed_min,
        move_start});
    done_pulse();
    chk("two end", {1'h1, 1'h0}, {reference_done, two_speed_busy});
    finish_test();
  end
endmodule : tb
